//--- src/csb_defs.vh
// Encodings, flag positions and timing counts for the compare/skip/branch decoder
`ifndef CSB_DEFS_VH
`define CSB_DEFS_VH

// Opcode match masks and values
`define CSB_CMP_IMM_MASK 16'hF000
`define CSB_CMP_IMM_VAL 16'h3000
`define CSB_SKIP_REG_MASK 16'hFE08
`define CSB_SKIP_REG_CLR_VAL 16'hFC00
`define CSB_SKIP_REG_SET_VAL 16'hFE00
`define CSB_SKIP_IO_MASK 16'hFF00
`define CSB_SKIP_IO_SET_VAL 16'h9B00
`define CSB_BRANCH_MASK 16'hFC00
`define CSB_BRANCH_SET_VAL 16'hF000
`define CSB_BRANCH_CLR_VAL 16'hF400

// Compare-immediate destination lies in the upper register half
`define CSB_CMP_IMM_REG_BASE 5'h10

// Flag positions in condition_flag_register
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_S 4
`define CSB_FLAG_H 5

// Extra cycles beyond the first
`define CSB_EXTRA_NONE 2'h0
`define CSB_EXTRA_BRANCH 2'h1
`define CSB_EXTRA_SKIP1 2'h1
`define CSB_EXTRA_SKIP2 2'h2

`endif

//--- src/csb_cmp_flags.v
// Flag generation for the compare-with-immediate subtraction
`timescale 1ns/100ps
`default_nettype none
`include "csb_defs.vh"

module csb_cmp_flags (
  // Operands
  input wire [7:0] minuend,
  input wire [7:0] subtrahend,
  input wire [7:0] flagsIn,
  // Result
  output reg [7:0] flagsOut
);

  wire [7:0] diff;
  wire vFlag;

  assign diff = minuend - subtrahend;
  assign vFlag = (minuend[7] & ~subtrahend[7] & ~diff[7]) |
                 (~minuend[7] & subtrahend[7] & diff[7]);

  always @* begin
    flagsOut = flagsIn;
    flagsOut[`CSB_FLAG_C] = (~minuend[7] & subtrahend[7]) | (subtrahend[7] & diff[7]) |
                            (diff[7] & ~minuend[7]);
    flagsOut[`CSB_FLAG_Z] = (diff == 8'h00);
    flagsOut[`CSB_FLAG_N] = diff[7];
    flagsOut[`CSB_FLAG_V] = vFlag;
    flagsOut[`CSB_FLAG_S] = diff[7] ^ vFlag;
    flagsOut[`CSB_FLAG_H] = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & diff[3]) |
                            (diff[3] & ~minuend[3]);
  end

endmodule // csb_cmp_flags
`default_nettype wire

//--- src/csb_decode.v
// Execution of compare-immediate, bit-skip and flag-branch instructions
`timescale 1ns/100ps
`default_nettype none
`include "csb_defs.vh"

module csb_decode #(
  parameter PC_W = 16
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Instruction issue
  input wire instrValid,
  input wire [15:0] instrWord,
  input wire [PC_W-1:0] pcCur,
  input wire nextIsTwoWord,
  output wire instrReady,
  output wire opSupported,
  // Operand fetch
  output wire [4:0] regAddr,
  output wire [4:0] ioAddr,
  input wire [7:0] regOperand,
  input wire [7:0] ioOperand,
  input wire [7:0] flagsIn,
  // Results
  output reg pcLoad_reg,
  output reg [PC_W-1:0] pcValue_reg,
  output reg flagsWe_reg,
  output reg [7:0] flagsOut_reg,
  output reg done_reg,
  output wire busy
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  // Instruction kinds handled here; anything else is left to other decoders
  localparam OP_NONE = 3'h0;
  localparam OP_CMP_IMM = 3'h1;
  localparam OP_SKIP_REG_CLR = 3'h2;
  localparam OP_SKIP_REG_SET = 3'h3;
  localparam OP_SKIP_IO_SET = 3'h4;
  localparam OP_BRANCH_SET = 3'h5;
  localparam OP_BRANCH_CLR = 3'h6;

  // Picks one bit of a byte by a 3-bit index
  function bit_at;
    input [7:0] data;
    input [2:0] idx;
    begin
      bit_at = data[idx];
    end
  endfunction

  // Sorts a word into one kind; the encodings never overlap, so order is free
  function [2:0] op_kind;
    input [15:0] word;
    begin
      op_kind = OP_NONE;
      if ((word & `CSB_CMP_IMM_MASK) == `CSB_CMP_IMM_VAL) begin
        op_kind = OP_CMP_IMM;
      end
      if ((word & `CSB_SKIP_REG_MASK) == `CSB_SKIP_REG_CLR_VAL) begin
        op_kind = OP_SKIP_REG_CLR;
      end
      if ((word & `CSB_SKIP_REG_MASK) == `CSB_SKIP_REG_SET_VAL) begin
        op_kind = OP_SKIP_REG_SET;
      end
      if ((word & `CSB_SKIP_IO_MASK) == `CSB_SKIP_IO_SET_VAL) begin
        op_kind = OP_SKIP_IO_SET;
      end
      if ((word & `CSB_BRANCH_MASK) == `CSB_BRANCH_SET_VAL) begin
        op_kind = OP_BRANCH_SET;
      end
      if ((word & `CSB_BRANCH_MASK) == `CSB_BRANCH_CLR_VAL) begin
        op_kind = OP_BRANCH_CLR;
      end
    end
  endfunction

  wire [2:0] opKind;
  wire isCmpImmOp;
  wire isSkipRegClrOp;
  wire isSkipRegSetOp;
  wire isSkipIoSetOp;
  wire isBranchSetOp;
  wire isBranchClrOp;
  wire accept;
  wire [7:0] immK;
  wire [2:0] bitSel;
  wire [PC_W-1:0] branchOffset;
  wire [7:0] cmpFlags;
  reg skipTaken;
  reg branchTaken;
  reg [1:0] extraCycles;
  reg [PC_W-1:0] pcTarget;
  reg state_reg;
  reg state_next;
  reg [1:0] waitCnt_reg;
  reg [1:0] waitCnt_next;

  assign opKind = op_kind(instrWord);
  assign isCmpImmOp = (opKind == OP_CMP_IMM);
  assign isSkipRegClrOp = (opKind == OP_SKIP_REG_CLR);
  assign isSkipRegSetOp = (opKind == OP_SKIP_REG_SET);
  assign isSkipIoSetOp = (opKind == OP_SKIP_IO_SET);
  assign isBranchSetOp = (opKind == OP_BRANCH_SET);
  assign isBranchClrOp = (opKind == OP_BRANCH_CLR);
  assign opSupported = (opKind != OP_NONE);

  assign busy = (state_reg == ST_WAIT);
  assign instrReady = ~busy;
  // Unsupported words are left to other decoders and not consumed here
  assign accept = instrValid & instrReady & opSupported;

  assign immK = {instrWord[11:8], instrWord[3:0]};
  assign bitSel = instrWord[2:0];
  // Compare-immediate only reaches the upper sixteen registers
  assign regAddr = isCmpImmOp ? (`CSB_CMP_IMM_REG_BASE | {1'b0, instrWord[7:4]}) :
                   instrWord[8:4];
  assign ioAddr = instrWord[7:3];
  // Seven-bit signed word offset, sign-extended to the counter width
  assign branchOffset = {{(PC_W-7){instrWord[9]}}, instrWord[9:3]};

  csb_cmp_flags u_cmp_flags (
    .minuend(regOperand),
    .subtrahend(immK),
    .flagsIn(flagsIn),
    .flagsOut(cmpFlags)
  );

  // Outcome and next counter value
  always @* begin
    skipTaken = 1'b0;
    branchTaken = 1'b0;
    if (isSkipRegClrOp) begin
      skipTaken = ~bit_at(regOperand, bitSel);
    end
    if (isSkipRegSetOp) begin
      skipTaken = bit_at(regOperand, bitSel);
    end
    if (isSkipIoSetOp) begin
      skipTaken = bit_at(ioOperand, bitSel);
    end
    if (isBranchSetOp) begin
      branchTaken = bit_at(flagsIn, bitSel);
    end
    if (isBranchClrOp) begin
      branchTaken = ~bit_at(flagsIn, bitSel);
    end
    pcTarget = pcCur + {{(PC_W-1){1'b0}}, 1'b1};
    extraCycles = `CSB_EXTRA_NONE;
    if (skipTaken) begin
      if (nextIsTwoWord) begin
        pcTarget = pcCur + {{(PC_W-2){1'b0}}, 2'h3};
        extraCycles = `CSB_EXTRA_SKIP2;
      end else begin
        pcTarget = pcCur + {{(PC_W-2){1'b0}}, 2'h2};
        extraCycles = `CSB_EXTRA_SKIP1;
      end
    end
    if (branchTaken) begin
      pcTarget = pcCur + branchOffset + {{(PC_W-1){1'b0}}, 1'b1};
      extraCycles = `CSB_EXTRA_BRANCH;
    end
  end

  // Cycle sequencing
  always @* begin
    state_next = state_reg;
    waitCnt_next = waitCnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept && extraCycles != `CSB_EXTRA_NONE) begin
          state_next = ST_WAIT;
          waitCnt_next = extraCycles;
        end
      end
      ST_WAIT: begin
        waitCnt_next = waitCnt_reg - 2'h1;
        if (waitCnt_reg == 2'h1) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        waitCnt_next = 2'h0;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      waitCnt_reg <= 2'h0;
      pcLoad_reg <= 1'b0;
      pcValue_reg <= {PC_W{1'b0}};
      flagsWe_reg <= 1'b0;
      flagsOut_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      waitCnt_reg <= waitCnt_next;
      pcLoad_reg <= accept;
      if (accept) begin
        pcValue_reg <= pcTarget;
      end
      flagsWe_reg <= accept & isCmpImmOp;
      if (accept & isCmpImmOp) begin
        flagsOut_reg <= cmpFlags;
      end
      // Done is registered, so it is high in the cycle after the last cycle of the instruction
      done_reg <= (accept && extraCycles == `CSB_EXTRA_NONE) ||
                  (state_reg == ST_WAIT && waitCnt_reg == 2'h1);
    end
  end

endmodule // csb_decode
`default_nettype wire

//--- sim/csb_decode_chk.sv
// Timing and result checks for the compare/skip/branch decoder
`timescale 1ns/100ps
`default_nettype none
module csb_decode_chk #(
  parameter PC_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Issue
  input wire logic instrValid,
  input wire logic instrReady,
  input wire logic opSupported,
  input wire logic [15:0] instrWord,
  input wire logic [PC_W-1:0] pcCur,
  input wire logic nextIsTwoWord,
  input wire logic [7:0] regOperand,
  input wire logic [7:0] ioOperand,
  input wire logic [7:0] flagsIn,
  // Results
  input wire logic [PC_W-1:0] pcValue_reg,
  input wire logic flagsWe_reg,
  input wire logic done_reg,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire acc = instrValid && instrReady && opSupported;
  wire [2:0] b = instrWord[2:0];
  wire [PC_W-1:0] tgt = pcCur + {{(PC_W-7){instrWord[9]}}, instrWord[9:3]} + 1'b1;
  sequence s_two;
    busy ##1 !busy && done_reg;
  endsequence
  sequence s_three;
    busy ##1 busy ##1 !busy && done_reg;
  endsequence
  property p_compareImm;
    acc && instrWord[15:12] == 4'h3 |=> flagsWe_reg && done_reg && !busy
      && pcValue_reg == $past(pcCur) + 1'b1;
  endproperty
  a_compareImm: assert property (p_compareImm) else $error("compare not one cycle");
  property p_skipRegClr;
    acc && instrWord[15:9] == 7'h7E && !regOperand[b] && !nextIsTwoWord
      |=> pcValue_reg == $past(pcCur) + 2'd2 ##0 s_two;
  endproperty
  a_skipRegClr: assert property (p_skipRegClr) else $error("clear skip wrong");
  property p_skipRegSet;
    acc && instrWord[15:9] == 7'h7F && regOperand[b] && nextIsTwoWord
      |=> pcValue_reg == $past(pcCur) + 2'd3 ##0 s_three;
  endproperty
  a_skipRegSet: assert property (p_skipRegSet) else $error("set skip wrong");
  property p_skipIoSet;
    acc && instrWord[15:8] == 8'h9B && ioOperand[b]
      |=> pcValue_reg == $past(pcCur) + 2'd2 + $past(nextIsTwoWord);
  endproperty
  a_skipIoSet: assert property (p_skipIoSet) else $error("io skip wrong");
  property p_branchSet;
    acc && instrWord[15:10] == 6'h3C && flagsIn[b] |=> pcValue_reg == $past(tgt) ##0 s_two;
  endproperty
  a_branchSet: assert property (p_branchSet) else $error("branch set wrong");
  property p_branchClr;
    acc && instrWord[15:10] == 6'h3D && !flagsIn[b] |=> pcValue_reg == $past(tgt) ##0 s_two;
  endproperty
  a_branchClr: assert property (p_branchClr) else $error("branch clear wrong");
  property p_noFlag;
    acc && instrWord[15:12] != 4'h3 |=> !flagsWe_reg;
  endproperty
  a_noFlag: assert property (p_noFlag) else $error("flags written");
  property p_notTaken;
    acc && instrWord[15:10] == 6'h3C && !flagsIn[b]
      |=> done_reg && !busy && pcValue_reg == $past(pcCur) + 1'b1;
  endproperty
  a_notTaken: assert property (p_notTaken) else $error("untaken branch wrong");
endmodule // csb_decode_chk
bind csb_decode csb_decode_chk #(.PC_W(PC_W)) u_chk (.clk(clk), .arst_n(arst_n),
  .instrValid(instrValid), .instrReady(instrReady), .opSupported(opSupported),
  .instrWord(instrWord), .pcCur(pcCur), .nextIsTwoWord(nextIsTwoWord),
  .regOperand(regOperand), .ioOperand(ioOperand), .flagsIn(flagsIn),
  .pcValue_reg(pcValue_reg), .flagsWe_reg(flagsWe_reg), .done_reg(done_reg), .busy(busy));
`default_nettype wire

//--- sim/compare_skip_branch_decode_bench.sv
// Self-checking bench for the compare/skip/branch decoder
`timescale 1ns/100ps
`default_nettype none
module compare_skip_branch_decode_bench;
  localparam logic [15:0] BASE [7] = '{16'h3000, 16'hFC00, 16'hFE00, 16'h9B00, 16'hF000,
    16'hF400, 16'h0000};
  localparam logic [15:0] MASK [7] = '{16'h0FFF, 16'h01F7, 16'h01F7, 16'h00FF, 16'h03FF,
    16'h03FF, 16'h0000};
  logic clk = 0, arst_n = 0, instrValid = 0, nextIsTwoWord = 0;
  logic [15:0] instrWord = 16'h0000, pcCur = 16'h0000;
  logic [7:0] regOperand = 8'h00, ioOperand = 8'h00, flagsIn = 8'h00;
  wire instrReady, opSupported, pcLoad_reg, flagsWe_reg, done_reg, busy;
  wire [4:0] regAddr, ioAddr;
  wire [15:0] pcValue_reg;
  wire [7:0] flagsOut_reg;
  logic [31:0] seed = 32'hD4497D2B;
  logic [24:0] q [$];
  int miscompares = 0, checksDone = 0;
  csb_decode #(.PC_W(16)) dut (.clk(clk), .arst_n(arst_n), .instrValid(instrValid),
    .instrWord(instrWord), .pcCur(pcCur), .nextIsTwoWord(nextIsTwoWord),
    .instrReady(instrReady), .opSupported(opSupported), .regAddr(regAddr), .ioAddr(ioAddr),
    .regOperand(regOperand), .ioOperand(ioOperand), .flagsIn(flagsIn),
    .pcLoad_reg(pcLoad_reg), .pcValue_reg(pcValue_reg), .flagsWe_reg(flagsWe_reg),
    .flagsOut_reg(flagsOut_reg), .done_reg(done_reg), .busy(busy));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [24:0] got, input logic [24:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_addr(input logic [4:0] got, input logic [4:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic issue(input int t);
    logic [7:0] k, d, r;
    logic [2:0] b;
    logic tk, v;
    int n;
    // Offers while busy are ignored, so wait for ready
    for (n = 0; n < 5 && instrReady !== 1'b1; n++) @(posedge clk) #1;
    if (instrReady !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    seed = lfsr(seed);
    instrWord = BASE[t] | (seed[15:0] & MASK[t]);
    {regOperand, ioOperand, flagsIn} = seed[31:8];
    seed = lfsr(seed);
    pcCur = seed[15:0];
    nextIsTwoWord = seed[16];
    instrValid = 1'b1;
    b = instrWord[2:0];
    tk = t == 1 ? !regOperand[b] : t == 2 ? regOperand[b] : t == 3 ? ioOperand[b] :
      t == 4 ? flagsIn[b] : !flagsIn[b];
    d = regOperand;
    k = {instrWord[11:8], instrWord[3:0]};
    r = d - k;
    v = (d[7] & ~k[7] & ~r[7]) | (~d[7] & k[7] & r[7]);
    if (t == 0) q.push_back({1'b1, pcCur + 16'h0001, flagsIn[7:6],
      (~d[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~d[3]), r[7] ^ v, v, r[7], r == 8'h00, k > d});
    else if (t == 6) ;
    else if (!tk) q.push_back({1'b0, pcCur + 16'h0001, 8'h00});
    else if (t < 4) q.push_back({1'b0, pcCur + 16'h0002 + nextIsTwoWord, 8'h00});
    else q.push_back({1'b0, pcCur + {{9{instrWord[9]}}, instrWord[9:3]} + 16'h0001, 8'h00});
    #1;
    if (t == 0) check_addr(regAddr, {1'b1, instrWord[7:4]});
    if (t == 1 || t == 2) check_addr(regAddr, instrWord[8:4]);
    if (t == 3) check_addr(ioAddr, instrWord[7:3]);
    @(posedge clk) #1;
    if (t == 6) check({24'h0, opSupported}, 25'h0);
  endtask
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Results drain in issue order
  always @(negedge clk) begin
    if (pcLoad_reg === 1'b1) begin
      check({flagsWe_reg, pcValue_reg, flagsWe_reg ? flagsOut_reg : 8'h00},
        q.size() ? q.pop_front() : 25'bx);
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    for (int i = 0; i < 140; i++) issue(i % 7);
    for (int i = 0; i < 5; i++) @(posedge clk) #1 instrValid = 1'b0;
    check({24'h0, q.size() == 0}, 25'h1);
    report_and_stop();
  end
endmodule // compare_skip_branch_decode_bench
`default_nettype wire
